// ### src/tcmp_pkg.sv
// constants, types and mode decoding for the timer compare-output block
// assumes a 16-bit counter and registers reached by 32-bit APB words
package tcmp_pkg;

  // ************************************************
  // register map: indices, byte address = 4 * index
  // ************************************************
  localparam int         ADDR_W       = 12;
  localparam logic [7:0] IDX_CTRL_A   = 8'h80;
  localparam logic [7:0] IDX_CTRL_B   = 8'h81;
  localparam logic [7:0] IDX_COUNT    = 8'h82;
  localparam logic [7:0] IDX_CMP_A    = 8'h83;
  localparam logic [7:0] IDX_CMP_B    = 8'h84;
  localparam logic [7:0] IDX_TOP      = 8'h85;
  localparam logic [7:0] IDX_STATUS   = 8'h86;
  localparam logic [7:0] IDX_PORT_DIR = 8'h87;

  // ************************************************
  // field positions and reset values
  // ************************************************
  localparam int OM_A_LO = 6;
  localparam int OM_B_LO = 4;
  localparam int WML_LO  = 0;
  localparam int WMH_LO  = 3;
  localparam int ST_OVF  = 0;
  localparam int ST_MA   = 1;
  localparam int ST_MB   = 2;
  localparam int DIR_A   = 0;
  localparam int DIR_B   = 1;
  localparam logic [7:0]  CTRL_A_RST = 8'h00;
  localparam logic [7:0]  CTRL_A_MSK = 8'hf3;
  localparam logic [7:0]  CTRL_B_MSK = 8'h18;
  localparam logic [15:0] WORD_RST   = 16'h0000;

  // ************************************************
  // count limits
  // ************************************************
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hffff;
  localparam logic [15:0] TOP_FIX8   = 16'h00ff;
  localparam logic [15:0] TOP_FIX9   = 16'h01ff;
  localparam logic [15:0] TOP_FIX10  = 16'h03ff;

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [5:0] {
    CLS_NORMAL = 6'b000001,
    CLS_CTC    = 6'b000010,
    CLS_FAST   = 6'b000100,
    CLS_PC     = 6'b001000,
    CLS_PFC    = 6'b010000,
    CLS_RSVD   = 6'b100000
  } wave_cls_t;

  typedef enum logic [5:0] {
    TS_MAX   = 6'b000001,
    TS_FIX8  = 6'b000010,
    TS_FIX9  = 6'b000100,
    TS_FIX10 = 6'b001000,
    TS_CMPA  = 6'b010000,
    TS_REG   = 6'b100000
  } top_src_t;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } count_dir_t;

  // ************************************************
  // mode decoding
  // ************************************************
  function automatic wave_cls_t cls_of(input logic [3:0] m);
    case (m)
      4'h0:                   cls_of = CLS_NORMAL;
      4'h4, 4'hc:             cls_of = CLS_CTC;
      4'h5, 4'h6, 4'h7,
      4'he, 4'hf:             cls_of = CLS_FAST;
      4'h1, 4'h2, 4'h3,
      4'ha, 4'hb:             cls_of = CLS_PC;
      4'h8, 4'h9:             cls_of = CLS_PFC;
      default:                cls_of = CLS_RSVD;
    endcase
  endfunction

  function automatic top_src_t top_src_of(input logic [3:0] m);
    case (m)
      4'h1, 4'h5:             top_src_of = TS_FIX8;
      4'h2, 4'h6:             top_src_of = TS_FIX9;
      4'h3, 4'h7:             top_src_of = TS_FIX10;
      4'h4, 4'h9, 4'hb, 4'hf: top_src_of = TS_CMPA;
      4'h8, 4'ha, 4'hc, 4'he: top_src_of = TS_REG;
      default:                top_src_of = TS_MAX;
    endcase
  endfunction

  // channel a may toggle in pwm only in modes 9, 11 and 15, where its compare value sets the top, and in mode 14
  function automatic logic toggle_a_ok(input logic [3:0] m);
    toggle_a_ok = (m == 4'h9) || (m == 4'hb) || (m == 4'he) || (m == 4'hf) ||
                  (cls_of(m) == CLS_NORMAL) || (cls_of(m) == CLS_CTC);
  endfunction

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
    byte_addr = {2'b00, idx, 2'b00};
  endfunction

endpackage

// ### src/count_core.sv
// 16-bit counter with single- and dual-slope sequences
// assumes tick is a one-cycle enable in the ref_clk domain
`timescale 1ns/10ps
`default_nettype none
module count_core
  import tcmp_pkg::*;
(
  input  wire logic        ref_clk,   // system clock
  input  wire logic        rst_b,     // sync reset, low
  input  wire logic        tick,      // count enable
  input  wire wave_cls_t   cls,       // count sequence
  input  wire logic [15:0] top,       // current top value
  input  wire logic        load,      // software write
  input  wire logic [15:0] load_val,  // value written
  output logic      [15:0] count_r,   // count value
  output count_dir_t       dir_r      // slope
);

  logic [15:0] count_nxt;
  count_dir_t  dir_nxt;
  wire         at_top = (count_r == top);
  wire         at_bot = (count_r == CNT_BOTTOM);
  wire [15:0]  inc    = count_r + 16'h0001;
  wire [15:0]  dec    = count_r - 16'h0001;

  always_comb begin
    count_nxt = count_r;
    dir_nxt   = dir_r;
    if (load) begin
      count_nxt = load_val;
    end else if (tick) begin
      case (cls)
        CLS_NORMAL: count_nxt = inc;
        CLS_CTC, CLS_FAST: count_nxt = at_top ? CNT_BOTTOM : inc;
        CLS_PC, CLS_PFC: begin
          if (dir_r == DIR_UP) begin
            count_nxt = at_top ? dec : inc;
            dir_nxt   = at_top ? DIR_DOWN : DIR_UP;
          end else begin
            count_nxt = at_bot ? inc : dec;
            dir_nxt   = at_bot ? DIR_UP : DIR_DOWN;
          end
        end
        default: count_nxt = count_r;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      count_r <= WORD_RST;
      dir_r   <= DIR_UP;
    end else begin
      count_r <= count_nxt;
      dir_r   <= dir_nxt;
    end
  end

endmodule
`default_nettype wire

// ### src/wave_out_unit.sv
// one compare channel: waveform flip-flop and pin-takeover decision
// assumes match and the top/bottom events are sampled on the same tick
`timescale 1ns/10ps
`default_nettype none
module wave_out_unit
  import tcmp_pkg::*;
(
  input  wire logic       ref_clk,    // system clock
  input  wire logic       rst_b,      // sync reset, low
  input  wire logic       tick,       // count enable
  input  wire wave_cls_t  cls,        // waveform family
  input  wire logic [1:0] out_mode,   // output mode field
  input  wire logic       toggle_ok,  // mode 1 toggling allowed
  input  wire logic       match,      // count equals compare
  input  wire logic       cmp_at_top, // compare equals top
  input  wire logic       at_top,     // count equals top
  input  wire count_dir_t dir,        // slope
  output logic            wave_r,     // waveform level
  output logic            connected   // takes over the pin
);

  logic wave_nxt;
  wire  tog = (out_mode == 2'b01) && toggle_ok && match;

  always_comb begin
    wave_nxt = wave_r;
    if (tick) begin
      case (cls)
        CLS_NORMAL, CLS_CTC: begin
          if (match) begin
            case (out_mode)
              2'b01:   wave_nxt = ~wave_r;
              2'b10:   wave_nxt = 1'b0;
              2'b11:   wave_nxt = 1'b1;
              default: wave_nxt = wave_r;
            endcase
          end
        end
        CLS_FAST: begin
          if (out_mode[1]) begin
            // wrap to bottom wins; a match at top is ignored
            if (at_top)
              wave_nxt = ~out_mode[0];
            else if (match && !cmp_at_top)
              wave_nxt = out_mode[0];
          end else if (tog) begin
            wave_nxt = ~wave_r;
          end
        end
        CLS_PC, CLS_PFC: begin
          if (out_mode[1] && match)
            wave_nxt = (dir == DIR_UP) ? out_mode[0] : ~out_mode[0];
          else if (tog)
            wave_nxt = ~wave_r;
        end
        default: wave_nxt = wave_r;
      endcase
    end
  end

  // mode 1 without toggle permission leaves the pin to the port
  assign connected = (out_mode != 2'b00) && !((out_mode == 2'b01) && !toggle_ok);

  always_ff @(posedge ref_clk) begin
    if (!rst_b)
      wave_r <= 1'b0;
    else
      wave_r <= wave_nxt;
  end

endmodule
`default_nettype wire

// ### src/timer_compare_output_control.sv
// 16-bit timer with two compare channels, waveform modes and apb registers
// assumes an apb master on ref_clk and a one-cycle timer_tick from a prescaler
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module timer_compare_output_control
  import tcmp_pkg::*;
(
  input  wire logic              ref_clk,    // 200 mhz clock
  input  wire logic              rst_b,      // sync reset, low
  input  wire logic              psel,       // apb select
  input  wire logic              penable,    // apb access phase
  input  wire logic              pwrite,     // apb direction
  input  wire logic [ADDR_W-1:0] paddr,      // apb byte address
  input  wire logic [31:0]       pwdata,     // apb write data
  output logic      [31:0]       prdata,     // apb read data
  output logic                   pready,     // apb ready
  output logic                   pslverr,    // apb error
  input  wire logic              timer_tick, // count enable pulse
  input  wire logic              port_a_val, // port data for pin a
  input  wire logic              port_b_val, // port data for pin b
  output logic                   pin_a_o,    // pin a level
  output logic                   pin_a_oe_b, // pin a drive, low
  output logic                   pin_b_o,    // pin b level
  output logic                   pin_b_oe_b  // pin b drive, low
);

  // ************************************************
  // register state
  // ************************************************
  logic [7:0]  ctrl_a_r;
  logic [1:0]  wave_mode_high_r;
  logic [15:0] cmp_a_buf_r;
  logic [15:0] cmp_b_buf_r;
  logic [15:0] cmp_a_act_r;
  logic [15:0] cmp_b_act_r;
  logic [15:0] top_reg_r;
  logic        ovf_r;
  logic        match_a_r;
  logic        match_b_r;
  logic [1:0]  port_dir_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        pin_a_o_r;
  logic        pin_a_oe_b_r;
  logic        pin_b_o_r;
  logic        pin_b_oe_b_r;

  // ************************************************
  // mode decode
  // ************************************************
  wire [1:0]  out_mode_chan_a = ctrl_a_r[OM_A_LO +: 2];
  wire [1:0]  out_mode_chan_b = ctrl_a_r[OM_B_LO +: 2];
  wire [1:0]  wave_mode_low   = ctrl_a_r[WML_LO +: 2];
  wire [3:0]  wave_mode_sel   = {wave_mode_high_r, wave_mode_low};
  wave_cls_t  cls;
  top_src_t   top_src;
  logic [15:0] top_val;

  assign cls     = cls_of(wave_mode_sel);
  assign top_src = top_src_of(wave_mode_sel);

  always_comb begin
    case (top_src)
      TS_FIX8:  top_val = TOP_FIX8;
      TS_FIX9:  top_val = TOP_FIX9;
      TS_FIX10: top_val = TOP_FIX10;
      TS_CMPA:  top_val = cmp_a_act_r;
      TS_REG:   top_val = top_reg_r;
      default:  top_val = CNT_MAX;
    endcase
  end

  // ************************************************
  // counter
  // ************************************************
  logic [15:0] count_value;
  count_dir_t  dir;
  wire         wr_go;
  wire         wr_count;

  count_core u_count (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .tick     (timer_tick),
    .cls      (cls),
    .top      (top_val),
    .load     (wr_count),
    .load_val (pwdata[15:0]),
    .count_r  (count_value),
    .dir_r    (dir)
  );

  wire at_top  = (count_value == top_val);
  wire at_bot  = (count_value == CNT_BOTTOM);
  wire at_max  = (count_value == CNT_MAX);
  wire match_a = (count_value == cmp_a_act_r);
  wire match_b = (count_value == cmp_b_act_r);
  wire dual    = (cls == CLS_PC) || (cls == CLS_PFC);

  // ************************************************
  // events: buffer take-over and flags
  // ************************************************
  // pfc and fast take the buffer at bottom so both slopes see one value
  wire upd_now = timer_tick &&
                 (((cls == CLS_PC) && at_top) ||
                  (((cls == CLS_PFC) || (cls == CLS_FAST)) && at_bot));
  wire upd_imm = (cls == CLS_NORMAL) || (cls == CLS_CTC) || (cls == CLS_RSVD);

  // dual-slope flags at the bottom turn, fast at top, normal and ctc at max
  wire ovf_set = timer_tick &&
                 ((dual && at_bot && (dir == DIR_DOWN)) ||
                  ((cls == CLS_FAST) && at_top) ||
                  (((cls == CLS_NORMAL) || (cls == CLS_CTC)) && at_max));
  wire ma_set  = timer_tick && match_a && (cls != CLS_RSVD);
  wire mb_set  = timer_tick && match_b && (cls != CLS_RSVD);

  // ************************************************
  // compare channels
  // ************************************************
  logic wave_a;
  logic wave_b;
  logic conn_a;
  logic conn_b;

  wave_out_unit u_chan_a (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .tick       (timer_tick),
    .cls        (cls),
    .out_mode   (out_mode_chan_a),
    .toggle_ok  (toggle_a_ok(wave_mode_sel)),
    .match      (match_a),
    .cmp_at_top (cmp_a_act_r == top_val),
    .at_top     (at_top),
    .dir        (dir),
    .wave_r     (wave_a),
    .connected  (conn_a)
  );

  // channel b never toggles in the pwm families
  wave_out_unit u_chan_b (
    .ref_clk    (ref_clk),
    .rst_b      (rst_b),
    .tick       (timer_tick),
    .cls        (cls),
    .out_mode   (out_mode_chan_b),
    .toggle_ok  (upd_imm),
    .match      (match_b),
    .cmp_at_top (cmp_b_act_r == top_val),
    .at_top     (at_top),
    .dir        (dir),
    .wave_r     (wave_b),
    .connected  (conn_b)
  );

  // ************************************************
  // apb decode
  // ************************************************
  wire hit_ctrl_a = (paddr == byte_addr(IDX_CTRL_A));
  wire hit_ctrl_b = (paddr == byte_addr(IDX_CTRL_B));
  wire hit_count  = (paddr == byte_addr(IDX_COUNT));
  wire hit_cmp_a  = (paddr == byte_addr(IDX_CMP_A));
  wire hit_cmp_b  = (paddr == byte_addr(IDX_CMP_B));
  wire hit_top    = (paddr == byte_addr(IDX_TOP));
  wire hit_status = (paddr == byte_addr(IDX_STATUS));
  wire hit_dir    = (paddr == byte_addr(IDX_PORT_DIR));
  wire hit_any    = hit_ctrl_a | hit_ctrl_b | hit_count | hit_cmp_a |
                    hit_cmp_b | hit_top | hit_status | hit_dir;

  // one wait state keeps prdata, pready and pslverr straight from flops
  wire acc_first = psel && penable && !pready_r;
  assign wr_go   = psel && penable && pready_r && pwrite && !pslverr_r;
  assign wr_count = wr_go && hit_count;
  wire wr_ctrl_a = wr_go && hit_ctrl_a;
  wire wr_ctrl_b = wr_go && hit_ctrl_b;
  wire wr_cmp_a  = wr_go && hit_cmp_a;
  wire wr_cmp_b  = wr_go && hit_cmp_b;
  wire wr_top    = wr_go && hit_top;
  wire wr_status = wr_go && hit_status;
  wire wr_dir    = wr_go && hit_dir;

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl_a)
      rd_mux[7:0] = ctrl_a_r & CTRL_A_MSK;
    if (hit_ctrl_b)
      rd_mux[WMH_LO +: 2] = wave_mode_high_r;
    if (hit_count)
      rd_mux[15:0] = count_value;
    if (hit_cmp_a)
      rd_mux[15:0] = cmp_a_buf_r;
    if (hit_cmp_b)
      rd_mux[15:0] = cmp_b_buf_r;
    if (hit_top)
      rd_mux[15:0] = top_reg_r;
    if (hit_status)
      rd_mux[ST_MB:ST_OVF] = {match_b_r, match_a_r, ovf_r};
    if (hit_dir)
      rd_mux[DIR_B:DIR_A] = port_dir_r;
  end

  // ************************************************
  // flag next values: a set in the clearing cycle wins
  // ************************************************
  wire ovf_nxt = ovf_set | (ovf_r & ~(wr_status & pwdata[ST_OVF]));
  wire ma_nxt  = ma_set | (match_a_r & ~(wr_status & pwdata[ST_MA]));
  wire mb_nxt  = mb_set | (match_b_r & ~(wr_status & pwdata[ST_MB]));

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctrl_a_r         <= CTRL_A_RST;
      wave_mode_high_r <= 2'b00;
      port_dir_r       <= 2'b00;
      top_reg_r        <= WORD_RST;
      cmp_a_buf_r      <= WORD_RST;
      cmp_b_buf_r      <= WORD_RST;
    end else begin
      if (wr_ctrl_a)
        ctrl_a_r <= pwdata[7:0] & CTRL_A_MSK;
      if (wr_ctrl_b)
        wave_mode_high_r <= pwdata[WMH_LO +: 2];
      if (wr_dir)
        port_dir_r <= pwdata[DIR_B:DIR_A];
      if (wr_top)
        top_reg_r <= pwdata[15:0];
      if (wr_cmp_a)
        cmp_a_buf_r <= pwdata[15:0];
      if (wr_cmp_b)
        cmp_b_buf_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cmp_a_act_r <= WORD_RST;
      cmp_b_act_r <= WORD_RST;
    end else if (upd_imm || upd_now) begin
      cmp_a_act_r <= cmp_a_buf_r;
      cmp_b_act_r <= cmp_b_buf_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ovf_r     <= 1'b0;
      match_a_r <= 1'b0;
      match_b_r <= 1'b0;
    end else begin
      ovf_r     <= ovf_nxt;
      match_a_r <= ma_nxt;
      match_b_r <= mb_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= acc_first;
      pslverr_r <= acc_first && !hit_any;
      prdata_r  <= (acc_first && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ************************************************
  // pins
  // ************************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pin_a_o_r    <= 1'b0;
      pin_b_o_r    <= 1'b0;
      pin_a_oe_b_r <= 1'b1;
      pin_b_oe_b_r <= 1'b1;
    end else begin
      pin_a_o_r    <= conn_a ? wave_a : port_a_val;
      pin_b_o_r    <= conn_b ? wave_b : port_b_val;
      pin_a_oe_b_r <= ~port_dir_r[DIR_A];
      pin_b_oe_b_r <= ~port_dir_r[DIR_B];
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign pin_a_o    = pin_a_o_r;
  assign pin_b_o    = pin_b_o_r;
  assign pin_a_oe_b = pin_a_oe_b_r;
  assign pin_b_oe_b = pin_b_oe_b_r;

endmodule
`default_nettype wire

// ### bench/pin_load.sv
// external load on the two waveform pins
// assumes pull-ups on both pads when the device does not drive them
`timescale 1ns/10ps
`default_nettype none
module pin_load (
  input  wire logic pin_a_o,    // device level a
  input  wire logic pin_a_oe_b, // drive a, low
  input  wire logic pin_b_o,    // device level b
  input  wire logic pin_b_oe_b, // drive b, low
  output logic      pad_a,      // level at load a
  output logic      pad_b       // level at load b
);
  // an undriven pad floats to the pull-up, never to the last driven level
  assign pad_a = pin_a_oe_b ? 1'b1 : pin_a_o;
  assign pad_b = pin_b_oe_b ? 1'b1 : pin_b_o;
endmodule
`default_nettype wire

// ### bench/tcmp_properties.sv
// checker for bus timing and pin takeover of the timer compare block
// assumes it is bound to timer_compare_output_control
`timescale 1ns/10ps
`default_nettype none
module tcmp_properties
  import tcmp_pkg::*;
(
  input wire logic              ref_clk,    // clock
  input wire logic              rst_b,      // sync reset, low
  input wire logic              psel,       // apb select
  input wire logic              penable,    // apb access
  input wire logic              pwrite,     // apb direction
  input wire logic [ADDR_W-1:0] paddr,      // apb address
  input wire logic [31:0]       pwdata,     // apb write data
  input wire logic [31:0]       prdata,     // apb read data
  input wire logic              pready,     // apb ready
  input wire logic              pslverr,    // apb error
  input wire logic              timer_tick, // count enable
  input wire logic              port_a_val, // port data a
  input wire logic              port_b_val, // port data b
  input wire logic              pin_a_o,    // pin a level
  input wire logic              pin_a_oe_b, // pin a drive, low
  input wire logic              pin_b_o,    // pin b level
  input wire logic              pin_b_oe_b  // pin b drive, low
);
  // ***********
  // helper logic
  // ***********
  logic [1:0] om_a_r;
  logic [1:0] om_b_r;
  logic       done_w;
  logic       rd_ctl;
  logic       wr_ctl;
  logic       wr_dir;
  assign done_w = psel && penable && pready;
  assign rd_ctl = done_w && !pwrite && (paddr == {2'b00, IDX_CTRL_A, 2'b00});
  assign wr_ctl = done_w && pwrite && (paddr == {2'b00, IDX_CTRL_A, 2'b00});
  assign wr_dir = done_w && pwrite && (paddr == {2'b00, IDX_PORT_DIR, 2'b00});
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      om_a_r <= 2'h0;
      om_b_r <= 2'h0;
    end else if (wr_ctl) begin
      om_a_r <= pwdata[7:6];
      om_b_r <= pwdata[5:4];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_map: assert property (pready |-> pslverr == (paddr < 12'h200 || paddr > 12'h21c || paddr[1:0] != 2'b00))
    else $error("pslverr disagrees with map");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer cycle");
  a_ctrl_rsvd: assert property (rd_ctl |-> prdata[31:8] == 24'h0 && prdata[3:2] == 2'h0)
    else $error("reserved control bits not zero");
  a_ctrl_modes: assert property (rd_ctl |-> prdata[7:4] == {om_a_r, om_b_r})
    else $error("output mode fields read wrong");
  a_dir_drive: assert property (wr_dir |-> ##2 {pin_b_oe_b, pin_a_oe_b} == ~$past(pwdata[1:0], 2))
    else $error("drive enable does not follow direction");
  a_port_a_off: assert property ($past(rst_b) && $past(om_a_r) == 2'h0 |-> pin_a_o == $past(port_a_val))
    else $error("pin a not under port control");
  a_port_b_off: assert property ($past(rst_b) && $past(om_b_r) == 2'h0 |-> pin_b_o == $past(port_b_val))
    else $error("pin b not under port control");
  c_err: cover property (pready && pslverr);
  c_dir: cover property (wr_dir);
  c_fall: cover property ($fell(pin_a_o) && !pin_a_oe_b);
endmodule
bind timer_compare_output_control tcmp_properties chk_u (.ref_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_tick, .port_a_val, .port_b_val, .pin_a_o,
  .pin_a_oe_b, .pin_b_o, .pin_b_oe_b);
`default_nettype wire

// ### bench/test_timer_compare_output_control.sv
// self-checking bench for the timer compare-output block
// assumes the pin_load model on the pins and the bound property checker
`timescale 1ns/10ps
`default_nettype none
module test_timer_compare_output_control
  import tcmp_pkg::*;
;
  logic              ref_clk, rst_b, psel, penable, pwrite, timer_tick, port_a_val, port_b_val;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, rerr, pin_a_o, pin_a_oe_b, pin_b_o, pin_b_oe_b, pad_a, pad_b;
  int                fails, n_checks;
  timer_compare_output_control dut_u (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .timer_tick, .port_a_val, .port_b_val, .pin_a_o, .pin_a_oe_b,
    .pin_b_o, .pin_b_oe_b);
  pin_load load_u (.pin_a_o, .pin_a_oe_b, .pin_b_o, .pin_b_oe_b, .pad_a, .pad_b);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ***********
  // shared tasks
  // ***********
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask
  // pready, read data and error are taken at the rising edge that shows pready, then the request drops
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 8);
    if (pready !== 1'b1) begin
      $display("Error apb pready expected 1 seen %b", pready);
      fails++;
      give_verdict();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ends where the pin flop has taken the last tick's waveform
  task automatic ticks(input int n);
    @(posedge ref_clk);
    timer_tick <= 1'b1;
    repeat (n) @(posedge ref_clk);
    timer_tick <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // ***********
  // scenarios
  // ***********
  task automatic t_regs;
    apb(1'b0, IDX_CTRL_A, 32'h0);
    chk("ctrl_a reset", 32'h0, rd);
    chk("pin a drive off", 32'h1, 32'(pin_a_oe_b));
    apb(1'b1, IDX_CTRL_A, 32'hffffffff);
    apb(1'b0, IDX_CTRL_A, 32'h0);
    chk("ctrl_a bits", 32'hf3, rd);
    apb(1'b1, IDX_CTRL_B, 32'hff);
    apb(1'b0, IDX_CTRL_B, 32'h0);
    chk("ctrl_b bits", 32'h18, rd);
    apb(1'b0, 8'ha0, 32'h0);
    chk("unmapped err", 32'h1, 32'(rerr));
    apb(1'b1, IDX_PORT_DIR, 32'h3);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("pin a drive on", 32'h0, 32'(pin_a_oe_b));
    chk("pin b drive on", 32'h0, 32'(pin_b_oe_b));
  endtask
  task automatic t_nonpwm;
    logic [1:0] om[4] = '{2'h3, 2'h0, 2'h2, 2'h1};
    logic       pre[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic       post[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    apb(1'b1, IDX_CTRL_B, 32'h0);
    apb(1'b1, IDX_CMP_A, 32'h3);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, IDX_CTRL_A, {24'h0, om[i], 6'h0});
      apb(1'b1, IDX_COUNT, 32'h0);
      ticks(3);
      chk("pad a before match", 32'(pre[i]), 32'(pad_a));
      ticks(1);
      chk("pad a at match", 32'(post[i]), 32'(pad_a));
      chk("pad b port", 32'h1, 32'(pad_b));
    end
  endtask
  task automatic t_fast;
    apb(1'b1, IDX_CTRL_B, 32'h08);
    apb(1'b1, IDX_CMP_A, 32'h3);
    for (int i = 2; i < 4; i++) begin
      apb(1'b1, IDX_CTRL_A, 32'(i * 64 + 1));
      apb(1'b1, IDX_COUNT, 32'h0);
      ticks(4);
      chk("fast match", 32'(i - 2), 32'(pad_a));
      apb(1'b1, IDX_COUNT, 32'hff);
      ticks(1);
      chk("fast bottom", 32'(3 - i), 32'(pad_a));
    end
    apb(1'b1, IDX_CTRL_A, 32'h81);
    apb(1'b1, IDX_CMP_A, 32'hff);
    apb(1'b1, IDX_COUNT, 32'h0);
    ticks(1);
    apb(1'b1, IDX_COUNT, 32'hff);
    ticks(1);
    chk("match at top", 32'h1, 32'(pad_a));
  endtask
  task automatic t_toggle;
    apb(1'b1, IDX_CTRL_A, 32'h51);
    ticks(1);
    chk("mode 5 toggle off", 32'h0, 32'(pad_a));
    apb(1'b1, IDX_CTRL_B, 32'h18);
    apb(1'b1, IDX_CTRL_A, 32'h52);
    apb(1'b1, IDX_TOP, 32'h20);
    apb(1'b1, IDX_CMP_A, 32'h5);
    apb(1'b1, IDX_COUNT, 32'h0);
    port_a_val <= 1'b1;
    ticks(6);
    chk("mode 14 toggle a", 32'h0, 32'(pad_a));
    chk("mode 14 b port", 32'h1, 32'(pad_b));
  endtask
  task automatic t_dual;
    apb(1'b1, IDX_CTRL_B, 32'h10);
    apb(1'b1, IDX_CTRL_A, 32'hc0);
    apb(1'b1, IDX_TOP, 32'h10);
    apb(1'b1, IDX_CMP_A, 32'h3);
    apb(1'b1, IDX_COUNT, 32'h0);
    ticks(4);
    chk("up match", 32'h1, 32'(pad_a));
    ticks(25);
    chk("before down match", 32'h1, 32'(pad_a));
    ticks(1);
    chk("down match", 32'h0, 32'(pad_a));
    apb(1'b1, IDX_STATUS, 32'h7);
    ticks(2);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("overflow early", 32'h0, 32'(rd[ST_OVF]));
    ticks(1);
    apb(1'b0, IDX_STATUS, 32'h0);
    chk("overflow at bottom", 32'h1, 32'(rd[ST_OVF]));
    port_a_val <= 1'b0;
    apb(1'b1, IDX_CTRL_A, 32'h51);
    ticks(3);
    chk("mode 9 toggle a", 32'h1, 32'(pad_a));
    chk("mode 9 b port", 32'h1, 32'(pad_b));
  endtask
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    timer_tick = 1'b0;
    port_a_val = 1'b0;
    port_b_val = 1'b1;
    fails = 0;
    n_checks = 0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs();
    t_nonpwm();
    t_fast();
    t_toggle();
    t_dual();
    give_verdict();
  end
endmodule
`default_nettype wire
